//--- hdl/ddr_rd_pkg.sv
// constants, types and helpers shared by the read-path device model
// assumes a single 125 MHz clock and command pins already sampled on it
// Operation
// - extended load, dll reset, 200-cycle lock
// - activate opens row in addressed bank
// - column commands carry bank, column, auto precharge
// - first data after read latency, burst order
// - burst four joins seamlessly, eight is cut
// - reads to open rows, lengths 2/4/8, interrupt
// - burst stop ends read, eight gives four
// - auto precharge select low disables it on writes
package ddr_rd_pkg;
    localparam int          CLK_PERIOD_PS   = 8000;
    localparam int          DLL_LOCK_CLOCKS = 200;
    localparam logic [7:0]  DLL_LOCK_CYCLES = 8'(DLL_LOCK_CLOCKS);
    localparam logic [1:0]  REF_MIN         = 2'h2;
    localparam logic [7:0]  REG_CTRL        = 8'h00;
    localparam logic [7:0]  REG_STATUS      = 8'h04;
    localparam logic [7:0]  REG_MODE        = 8'h08;
    localparam logic [7:0]  REG_RDCNT       = 8'h0C;
    localparam logic [15:0] SEED_RST        = 16'hA5C3;
    localparam logic [2:0]  BL_RST          = 3'h2;
    localparam logic [2:0]  CL_RST          = 3'h2;
    localparam int          MODE_BT_BIT     = 3;
    localparam int          MODE_CL_LSB     = 4;
    localparam int          DLL_RESET_BIT   = 8;
    localparam int          AP_SELECT_BIT   = 10;
    localparam int          EXT_DLLDIS_BIT  = 0;
    localparam logic [1:0]  BA_MODE         = 2'h0;
    localparam logic [1:0]  BA_EXT_MODE     = 2'h1;
    localparam logic [2:0]  CL_CODE_2       = 3'h2;
    localparam logic [2:0]  CL_CODE_3       = 3'h3;
    localparam logic [2:0]  CL_CODE_25      = 3'h6;

    typedef enum logic [2:0] {
        CMD_MODE_LOAD = 3'h0, CMD_REFRESH = 3'h1, CMD_PRECHARGE = 3'h2,
        CMD_ACTIVATE  = 3'h3, CMD_WRITE   = 3'h4, CMD_READ      = 3'h5,
        CMD_BURST_STOP = 3'h6, CMD_NO_OP  = 3'h7
    } cmd_e;

    typedef enum logic [2:0] {
        INIT_WAIT_CKE = 3'h0, INIT_WAIT_PRE = 3'h1, INIT_WAIT_EXT = 3'h2,
        INIT_WAIT_DLLRST = 3'h3, INIT_WAIT_PRE2 = 3'h4, INIT_WAIT_REF = 3'h5,
        INIT_WAIT_MODE = 3'h6, INIT_READY = 3'h7
    } init_e;

    typedef struct packed {
        logic        cke;
        logic        csN;
        logic        rasN;
        logic        casN;
        logic        weN;
        logic [1:0]  ba;
        logic [12:0] addr;
    } ddr_cmd_s;

    typedef struct packed {
        logic        valid;
        logic        stop;
        logic [1:0]  bank;
        logic [12:0] row;
        logic [9:0]  col;
    } rd_event_s;

    typedef struct packed {
        logic        dqOe;
        logic [15:0] dqRise;
        logic [15:0] dqFall;
        logic        dqsOe;
        logic        dqsRise;
        logic        dqsFall;
    } rd_out_s;

    // pairs of data elements per burst: lengths 2, 4, 8
    function automatic logic [2:0] blPairs(input logic [2:0] blCode);
        case (blCode)
            3'h1:    blPairs = 3'h1;
            3'h3:    blPairs = 3'h4;
            default: blPairs = 3'h2;
        endcase
    endfunction

    // column of element i, wrapping inside the burst block
    function automatic logic [9:0] burstCol(input logic [9:0] col, input logic [2:0] i,
                                            input logic [2:0] blCode, input logic bt);
        logic [2:0] m;
        logic [2:0] low;
        m   = 3'({blPairs(blCode), 1'b0} - 4'h1);
        low = bt ? (col[2:0] ^ i) : 3'(col[2:0] + i);
        burstCol = {col[9:3], (col[2:0] & ~m) | (low & m)};
    endfunction

    // no storage array: read data is a pattern of the location and the seed
    function automatic logic [15:0] dataOf(input logic [15:0] seed, input logic [1:0] bank,
                                           input logic [12:0] row, input logic [9:0] col);
        dataOf = seed ^ {row[5:0], bank, col[7:0]};
    endfunction
endpackage

//--- hdl/rd_event_delay.sv
// delay line for read and burst-stop events, tap chosen by latency
// assumes tap is stable while events are in flight
`timescale 1ns/1ps
module rd_event_delay
    import ddr_rd_pkg::*;
#(
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rstn,
    // events
    input  wire rd_event_s evIn,
    input  wire logic      tap,
    output rd_event_s      evOut
);
    rd_event_s [DEPTH-1:0] pipe_q;
    rd_event_s [DEPTH-1:0] pipe_d;

    always_comb begin
        pipe_d = {pipe_q[DEPTH-2:0], evIn};
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pipe_q <= '0;
        end else begin
            pipe_q <= pipe_d;
        end
    end

    assign evOut = pipe_q[tap];
endmodule

//--- hdl/ddr_read_device.sv
// device-side command decode, initialisation tracking and read path
// assumes command pins synchronous to clk; one clk stands for one device clock
`timescale 1ns/1ps
module ddr_read_device
    import ddr_rd_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // command pins
    input  wire ddr_cmd_s    cmdPins,
    // read data pins, rise and fall halves
    output rd_out_s          rdOut,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    typedef struct packed {
        init_e              init;
        logic [1:0]         refCnt;
        logic [7:0]         lockCnt;
        logic               dllLocked;
        logic               dllEnabled;
        logic [2:0]         blCode;
        logic               bt;
        logic [2:0]         clCode;
        logic [3:0]         openValid;
        logic [3:0][12:0]   openRow;
        rd_event_s          eng;
        logic [1:0]         engIdx;
        logic [2:0]         engLeft;
        logic [15:0]        heldFall;
        logic               heldValid;
        rd_out_s            out;
        logic [15:0]        seed;
        logic [31:0]        readCnt;
        logic [31:0]        prdata;
        logic               pready;
        logic               pslverr;
    } state_s;

    state_s    q;
    state_s    d;
    cmd_e      cmd;
    logic      cmdReady;
    logic      readTaken;
    logic      bstTaken;
    logic      apOn;
    rd_event_s evIn;
    rd_event_s evDly;
    logic [31:0] rdMux;

    assign cmd       = (cmdPins.cke && !cmdPins.csN)
                     ? cmd_e'({cmdPins.rasN, cmdPins.casN, cmdPins.weN}) : CMD_NO_OP;
    assign apOn      = cmdPins.addr[AP_SELECT_BIT];
    assign cmdReady  = (q.init == INIT_READY) && q.dllLocked;
    assign readTaken = (cmd == CMD_READ) && cmdReady && q.openValid[cmdPins.ba];
    assign bstTaken  = (cmd == CMD_BURST_STOP) && cmdReady;
    assign evIn      = '{valid: readTaken || bstTaken, stop: bstTaken, bank: cmdPins.ba,
                         row: q.openRow[cmdPins.ba], col: cmdPins.addr[9:0]};

    // latency 3 waits one cycle longer; 2.5 reuses the 2 tap plus a half shift
    rd_event_delay #(.DEPTH(2)) u_delay (
        .clk   (clk),
        .rstn  (rstn),
        .evIn  (evIn),
        .tap   (q.clCode == CL_CODE_3),
        .evOut (evDly)
    );

    always_comb begin
        case (paddr)
            REG_CTRL:   rdMux = {16'h0000, q.seed};
            REG_STATUS: rdMux = {20'h00000, q.openValid, 2'h0, (q.engLeft != 3'h0),
                                 q.dllEnabled, q.dllLocked, q.init};
            REG_MODE:   rdMux = {25'h0000000, q.clCode, q.bt, q.blCode};
            REG_RDCNT:  rdMux = q.readCnt;
            default:    rdMux = 32'h00000000;
        endcase
    end

    always_comb begin
        logic        riseV;
        logic        fallV;
        logic [15:0] e0;
        logic [15:0] e1;
        riseV = 1'b0;
        fallV = 1'b0;
        e0    = 16'h0000;
        e1    = 16'h0000;
        d     = q;

        // initialisation sequence as seen from the pins
        case (q.init)
            INIT_WAIT_CKE: begin
                if (cmdPins.cke) d.init = INIT_WAIT_PRE;
            end
            INIT_WAIT_PRE: begin
                if (cmd == CMD_PRECHARGE && apOn) d.init = INIT_WAIT_EXT;
            end
            INIT_WAIT_EXT: begin
                if (cmd == CMD_MODE_LOAD && cmdPins.ba == BA_EXT_MODE &&
                    !cmdPins.addr[EXT_DLLDIS_BIT]) d.init = INIT_WAIT_DLLRST;
            end
            INIT_WAIT_DLLRST: begin
                if (cmd == CMD_MODE_LOAD && cmdPins.ba == BA_MODE &&
                    cmdPins.addr[DLL_RESET_BIT]) d.init = INIT_WAIT_PRE2;
            end
            INIT_WAIT_PRE2: begin
                if (cmd == CMD_PRECHARGE && apOn) begin
                    d.init   = INIT_WAIT_REF;
                    d.refCnt = 2'h0;
                end
            end
            INIT_WAIT_REF: begin
                if (cmd == CMD_REFRESH && q.refCnt != 2'h3) d.refCnt = q.refCnt + 2'h1;
                if (q.refCnt >= REF_MIN) d.init = INIT_WAIT_MODE;
            end
            INIT_WAIT_MODE: begin
                if (cmd == CMD_MODE_LOAD && cmdPins.ba == BA_MODE &&
                    !cmdPins.addr[DLL_RESET_BIT]) d.init = INIT_READY;
            end
            INIT_READY: d.init = INIT_READY;
            default:    d.init = INIT_WAIT_CKE;
        endcase

        // dll lock countdown; a new reset restarts it
        if (q.lockCnt != 8'h00) begin
            d.lockCnt = q.lockCnt - 8'h01;
            if (q.lockCnt == 8'h01) d.dllLocked = q.dllEnabled;
        end
        if (cmd == CMD_MODE_LOAD && cmdPins.ba == BA_MODE) begin
            d.blCode = cmdPins.addr[2:0];
            d.bt     = cmdPins.addr[MODE_BT_BIT];
            d.clCode = cmdPins.addr[MODE_CL_LSB +: 3];
            if (cmdPins.addr[DLL_RESET_BIT]) begin
                d.lockCnt   = DLL_LOCK_CYCLES;
                d.dllLocked = 1'b0;
            end
        end
        if (cmd == CMD_MODE_LOAD && cmdPins.ba == BA_EXT_MODE) begin
            d.dllEnabled = !cmdPins.addr[EXT_DLLDIS_BIT];
            if (cmdPins.addr[EXT_DLLDIS_BIT]) d.dllLocked = 1'b0;
        end

        // bank rows; auto precharge closes the bank as the column command is taken
        if (cmd == CMD_ACTIVATE && q.init == INIT_READY) begin
            d.openValid[cmdPins.ba] = 1'b1;
            d.openRow[cmdPins.ba]   = cmdPins.addr;
        end
        if (cmd == CMD_PRECHARGE) begin
            if (apOn) d.openValid = 4'h0;
            else d.openValid[cmdPins.ba] = 1'b0;
        end
        if ((readTaken || (cmd == CMD_WRITE && cmdReady)) && apOn) begin
            d.openValid[cmdPins.ba] = 1'b0;
        end
        if (readTaken) d.readCnt = q.readCnt + 32'h1;

        // burst engine: a new read replaces, a stop empties
        if (evDly.valid && evDly.stop) begin
            d.engLeft = 3'h0;
        end else if (evDly.valid) begin
            d.eng     = evDly;
            d.engIdx  = 2'h0;
            d.engLeft = blPairs(q.blCode);
        end
        if (d.engLeft != 3'h0) begin
            e0 = dataOf(q.seed, d.eng.bank, d.eng.row,
                        burstCol(d.eng.col, {d.engIdx, 1'b0}, q.blCode, q.bt));
            e1 = dataOf(q.seed, d.eng.bank, d.eng.row,
                        burstCol(d.eng.col, {d.engIdx, 1'b1}, q.blCode, q.bt));
            d.engIdx  = d.engIdx + 2'h1;
            d.engLeft = d.engLeft - 3'h1;
            riseV     = 1'b1;
            fallV     = 1'b1;
        end
        // half-cycle latency: rise half carries last fall element
        if (q.clCode == CL_CODE_25) begin
            d.out.dqRise = q.heldFall;
            d.out.dqFall = e0;
            d.heldFall   = e1;
            d.heldValid  = riseV;
            fallV        = riseV;
            riseV        = q.heldValid;
        end else begin
            d.out.dqRise = e0;
            d.out.dqFall = e1;
            d.heldValid  = 1'b0;
        end
        d.out.dqOe    = riseV || fallV;
        d.out.dqsOe   = riseV || fallV;
        d.out.dqsRise = riseV || fallV;
        d.out.dqsFall = 1'b0;

        // apb: answer registered in setup, so access phase always sees pready
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        if (psel && !penable) begin
            d.pready  = 1'b1;
            d.prdata  = rdMux;
            d.pslverr = !(paddr == REG_CTRL || paddr == REG_STATUS ||
                          paddr == REG_MODE || paddr == REG_RDCNT);
        end
        if (psel && penable && q.pready && pwrite && paddr == REG_CTRL) begin
            d.seed = pwdata[15:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q        <= '0;
            q.init   <= INIT_WAIT_CKE;
            q.blCode <= BL_RST;
            q.clCode <= CL_RST;
            q.seed   <= SEED_RST;
        end else begin
            q <= d;
        end
    end

    assign rdOut   = q.out;
    assign prdata  = q.prdata;
    assign pready  = q.pready;
    assign pslverr = q.pslverr;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_dll_lock_wait: assert property (
        (cmd == CMD_MODE_LOAD && cmdPins.ba == BA_MODE && cmdPins.addr[DLL_RESET_BIT])
        |=> !q.dllLocked [*8]) else $error("dll locked too soon after reset");
    chk_row_opens: assert property (
        (cmd == CMD_ACTIVATE && q.init == INIT_READY)
        |=> q.openValid[$past(cmdPins.ba)] && q.openRow[$past(cmdPins.ba)] == $past(cmdPins.addr))
        else $error("activate did not open row");
    chk_read_autopre: assert property (
        (readTaken && apOn) |=> !q.openValid[$past(cmdPins.ba)])
        else $error("auto precharge read left bank open");
    chk_read_latency: assert property (
        (readTaken && q.clCode == CL_CODE_2) |-> ##2 q.out.dqOe)
        else $error("first data not at latency two");
    chk_concat_four: assert property (
        (readTaken && q.clCode == CL_CODE_2 && q.blCode == 3'h2) ##2 readTaken
        |-> q.out.dqOe [*4]) else $error("burst of four not joined");
    chk_closed_bank: assert property (
        (cmd == CMD_READ && !q.openValid[cmdPins.ba]) |=> q.readCnt == $past(q.readCnt))
        else $error("read to closed bank taken");
    chk_stop_four: assert property (
        (readTaken && q.clCode == CL_CODE_2 && q.blCode == 3'h3) ##1 !readTaken ##1 bstTaken
        |-> q.out.dqOe ##1 q.out.dqOe ##1 !q.out.dqOe) else $error("stopped burst not four");
    chk_write_noap: assert property (
        (cmd == CMD_WRITE && cmdReady && !apOn && q.openValid[cmdPins.ba])
        |=> q.openValid[$past(cmdPins.ba)]) else $error("write without auto precharge closed bank");
    chk_strobe_data: assert property (
        q.out.dqOe |-> q.out.dqsOe && q.out.dqsRise && !q.out.dqsFall)
        else $error("strobe not with data");

    cov_init_done: cover property ($rose(q.init == INIT_READY));
    cov_half_lat:  cover property (readTaken && q.clCode == CL_CODE_25);
    cov_stopped:   cover property (bstTaken && q.engLeft != 3'h0);
    cov_concat:    cover property (readTaken ##2 readTaken);
endmodule

//--- tb/ddr_host_model.sv
// host controller model driving the command pins
// assumes one caller at a time; a no-op follows every command
`timescale 1ns/1ps
module ddr_host_model
    import ddr_rd_pkg::*;
#(
    parameter int STABLE_CYCLES = 64, // shortened stand-in for the 200 us wait
    parameter int RAS_CYCLES    = 5,
    parameter int RC_CYCLES     = 7,
    parameter int RD_PRE_CYCLES = 4
) (
    // clock
    input  wire logic clk,
    // command pins
    output ddr_cmd_s  cmdPins
);
    int cyc;
    int lastCyc;
    int rdAt;
    int actAt[4];

    initial begin
        cyc = 0;
        rdAt = -100;
        actAt = '{-100, -100, -100, -100};
        cmdPins = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 2'h0, 13'h0000};
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
    end

    // spacing is enforced here rather than trusted to the caller
    task automatic issue(input cmd_e c, input logic [1:0] b, input logic [12:0] a);
        @(posedge clk);
        while ((c == CMD_PRECHARGE && cyc + 1 - actAt[b] < RAS_CYCLES)
               || (c == CMD_PRECHARGE && cyc + 1 - rdAt < RD_PRE_CYCLES)
               || (c == CMD_ACTIVATE && cyc + 1 - actAt[b] < RC_CYCLES)) begin
            @(posedge clk);
        end
        lastCyc = cyc + 1;
        if (c == CMD_ACTIVATE) begin
            actAt[b] = lastCyc;
        end
        if (c == CMD_READ) begin
            rdAt = lastCyc;
        end
        {cmdPins.rasN, cmdPins.casN, cmdPins.weN} <= c;
        cmdPins.ba <= b;
        cmdPins.addr <= a;
        @(posedge clk);
        {cmdPins.rasN, cmdPins.casN, cmdPins.weN} <= CMD_NO_OP;
        // idle address lines do not keep the last value
        cmdPins.ba <= ~b;
        cmdPins.addr <= ~a;
    endtask

    task automatic init_head();
        repeat (STABLE_CYCLES) @(posedge clk);
        cmdPins.cke <= 1'b1;
        issue(CMD_PRECHARGE, 2'h0, 13'h0400);
        issue(CMD_MODE_LOAD, BA_EXT_MODE, 13'h0000);
        issue(CMD_MODE_LOAD, BA_MODE, 13'h0122);
    endtask

    task automatic init_tail();
        repeat (DLL_LOCK_CLOCKS) @(posedge clk);
        issue(CMD_PRECHARGE, 2'h0, 13'h0400);
        repeat (2) issue(CMD_REFRESH, 2'h0, 13'h0000);
        issue(CMD_MODE_LOAD, BA_MODE, 13'h0022);
    endtask
endmodule

//--- tb/testbench.sv
// self-checking bench: apb registers, initialisation and read traffic
// assumes the host model drives every command pin and counts cycles
`timescale 1ns/1ps
module testbench;
    import ddr_rd_pkg::*;
    logic        clk;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] r;
    logic        e;
    logic [15:0] seed;
    ddr_cmd_s    cmdPins;
    rd_out_s     rdOut;
    logic        oeAt[int];
    logic [15:0] riseAt[int];
    logic [15:0] fallAt[int];
    int          fails;
    int          cmp_count;

    ddr_host_model host (.clk(clk), .cmdPins(cmdPins));
    ddr_read_device uut (
        .clk(clk), .rstn(rstn), .cmdPins(cmdPins), .rdOut(rdOut),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        if (fails == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // settled outputs, one sample per cycle
    always @(negedge clk) begin
        oeAt[host.cyc] = rdOut.dqOe;
        riseAt[host.cyc] = rdOut.dqRise;
        fallAt[host.cyc] = rdOut.dqFall;
        if (rdOut.dqOe === 1'b1)
            check("strobe", 32'({rdOut.dqsOe, rdOut.dqsRise, rdOut.dqsFall}), 32'h6);
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no assumed wait count: only the watchdog ends a hung transfer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic burst(input logic [1:0] b, input logic [12:0] row, input logic [9:0] col,
                         input int n, input int f, input int h, input int blen, input logic bt);
        logic [2:0] m;
        logic [2:0] lo;
        logic [9:0] c;
        int         j;
        m = 3'(blen - 1);
        for (int k = 0; k < n; k++) begin
            lo = bt ? col[2:0] ^ 3'(k) : 3'(col[2:0] + 3'(k));
            c = {col[9:3], (col[2:0] & ~m) | (lo & m)};
            j = k + h;
            check("data", 32'(j % 2 ? fallAt[f + j / 2] : riseAt[f + j / 2]),
                  32'(seed ^ {row[5:0], b, c[7:0]}));
        end
    endtask

    task automatic span(input int f, input int n);
        check("oe lead", 32'(oeAt[f - 1]), 32'h0);
        for (int i = 0; i < n; i++) check("oe", 32'(oeAt[f + i]), 32'h1);
        check("oe tail", 32'(oeAt[f + n]), 32'h0);
    endtask

    task automatic t_regs();
        apb(1'b0, REG_CTRL, 32'h0);
        check("ctrl", r, {16'h0, SEED_RST});
        apb(1'b0, REG_STATUS, 32'h0);
        check("status", r, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        check("slverr", {31'h0, e}, 32'h1);
        check("unmapped", r, 32'h0);
        apb(1'b1, REG_MODE, 32'h0000_0077);
        apb(1'b1, REG_CTRL, 32'h0000_3C5A);
        seed = 16'h3C5A;
        apb(1'b0, REG_CTRL, 32'h0);
        check("seed", r, 32'h3C5A);
        apb(1'b0, REG_MODE, 32'h0);
        check("mode", r, 32'h22);
    endtask

    task automatic t_init();
        host.init_head();
        apb(1'b0, REG_STATUS, 32'h0);
        check("locked", {31'h0, r[3]}, 32'h0);
        host.issue(CMD_ACTIVATE, 2'h0, 13'h0001);
        host.issue(CMD_READ, 2'h0, 13'h0000);
        repeat (6) @(posedge clk);
        span(host.lastCyc + 2, 0);
        host.init_tail();
        apb(1'b0, REG_STATUS, 32'h0);
        check("ready", {27'h0, r[4:0]}, 32'h1F);
        apb(1'b0, REG_RDCNT, 32'h0);
        check("rdcnt", r, 32'h0);
    endtask

    task automatic t_reads();
        logic [2:0] clc[3] = '{CL_CODE_2, CL_CODE_25, CL_CODE_3};
        int         lat[3] = '{2, 2, 3};
        int         hf[3] = '{0, 1, 0};
        int         bl;
        for (int i = 0; i < 9; i++) begin
            bl = 2 << (i % 3);
            host.issue(CMD_MODE_LOAD, BA_MODE, {6'h0, clc[i / 3], 1'(i), 3'(i % 3 + 1)});
            host.issue(CMD_ACTIVATE, 2'(i), 13'h0A5A);
            host.issue(CMD_READ, 2'(i), 13'(10'h0B5 + 10'(i)));
            repeat (9) @(posedge clk);
            burst(2'(i), 13'h0A5A, 10'h0B5 + 10'(i), bl, host.rdAt + lat[i / 3], hf[i / 3],
                  bl, 1'(i));
            span(host.rdAt + lat[i / 3], (bl + hf[i / 3] + 1) / 2);
            host.issue(CMD_PRECHARGE, 2'(i), 13'h0000);
        end
    endtask

    task automatic t_concat(input logic [2:0] blc, input int bl);
        int f;
        host.issue(CMD_MODE_LOAD, BA_MODE, {6'h0, CL_CODE_2, 1'b0, blc});
        host.issue(CMD_ACTIVATE, 2'h1, 13'h0133);
        host.issue(CMD_READ, 2'h1, 13'h0010);
        f = host.lastCyc + 2;
        host.issue(CMD_READ, 2'h1, 13'h0024);
        repeat (9) @(posedge clk);
        burst(2'h1, 13'h0133, 10'h010, 4, f, 0, bl, 1'b0);
        burst(2'h1, 13'h0133, 10'h024, bl, f + 2, 0, bl, 1'b0);
        span(f, 2 + bl / 2);
        host.issue(CMD_PRECHARGE, 2'h1, 13'h0000);
    endtask

    task automatic t_stop();
        int          f;
        logic [31:0] cnt;
        host.issue(CMD_MODE_LOAD, BA_MODE, {6'h0, CL_CODE_3, 1'b0, 3'h3});
        host.issue(CMD_ACTIVATE, 2'h2, 13'h0077);
        host.issue(CMD_READ, 2'h2, 13'h0040);
        f = host.lastCyc + 3;
        host.issue(CMD_BURST_STOP, 2'h0, 13'h0000);
        host.issue(CMD_WRITE, 2'h2, 13'h0008);
        host.issue(CMD_READ, 2'h2, 13'h0048);
        repeat (12) @(posedge clk);
        burst(2'h2, 13'h0077, 10'h040, 4, f, 0, 8, 1'b0);
        span(f, 2);
        burst(2'h2, 13'h0077, 10'h048, 8, host.lastCyc + 3, 0, 8, 1'b0);
        apb(1'b0, REG_RDCNT, 32'h0);
        cnt = r;
        host.issue(CMD_WRITE, 2'h2, 13'h0408);
        host.issue(CMD_READ, 2'h2, 13'h0048);
        repeat (8) @(posedge clk);
        span(host.lastCyc + 3, 0);
        apb(1'b0, REG_RDCNT, 32'h0);
        check("rdcnt", r, cnt);
        // read with auto precharge is taken, then closes the bank for the next read
        host.issue(CMD_ACTIVATE, 2'h2, 13'h0077);
        host.issue(CMD_READ, 2'h2, 13'h0448);
        host.issue(CMD_READ, 2'h2, 13'h0048);
        repeat (8) @(posedge clk);
        apb(1'b0, REG_RDCNT, 32'h0);
        check("rdcnt ap", r, cnt + 32'h1);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        test_done();
    end

    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fails = 0;
        cmp_count = 0;
        seed = SEED_RST;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_init();
        t_reads();
        t_concat(3'h2, 4);
        t_concat(3'h3, 8);
        t_stop();
        test_done();
    end
endmodule
